// ===== core/asrtc_serial_out.sv
// Serial result output with tag chaining, saturation and reference off.
// Assumes conversion start and done come from the converter core on
// SYS_CLK; the external shift clock and tag are pins.
//
// Summary of operation
// - Previous result readable 12 us after start
// - Tag sampled on active shift clock
// - External clock: tag bits follow LSB
// - Internal clock: first tag after 16 bits
// - Out-of-range inputs saturate to full scale
// - Reference shutdown powers internal reference down
// - Busy rises in the same cycle as the result register update
// - External clock: MSB first falling edge, LSB sixteenth
// - Internal mode: sixteen pulses, then clock low
`timescale 1ns/1ns
`default_nettype none
module asrtc_serial_out (
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        EXT_SHIFT_CLK,
  input  wire logic        SHIFT_CLOCK_SOURCE_SELECT,
  input  wire logic        DAISY_CHAIN_INPUT,
  input  wire logic        CONV_START,
  input  wire logic        CONV_DONE,
  input  wire logic [17:0] CONV_RAW,
  input  wire logic        REFERENCE_SHUTDOWN,
  output logic             SERIAL_RESULT_OUT,
  output logic             SHIFT_CLOCK_PIN,
  output logic             BUSY_N,
  output logic             REF_POWER_EN,
  output logic             PREV_DATA_VALID
);
  import asrtc_pkg::*;
  logic [15:0]   result_r;
  logic          busy_n_r;
  logic [CNT_W-1:0] prev_cnt_r;
  logic          prev_valid_r;
  logic          sel_s1_r, sel_s2_r;
  logic          tag_s1_r, tag_s2_r;
  logic          ref_s1_r, ref_s2_r;
  logic          load_clr_r;
  logic          ext_s1_r, ext_s2_r;
  logic          ext_out;
  asrtc_ick_t    ick_r;
  logic [CNT_W-1:0] ick_cnt_r;
  logic [4:0]    pulse_r;
  logic          sclk_r;
  logic [15:0]   int_sh_r;
  logic          int_tag_r;
  logic          int_out_r;
  logic          tag_taken_r;
  logic          out_r;

  // Signed 18-bit raw result clipped to 16-bit two's complement
  function automatic logic [15:0] saturate(input logic [17:0] raw);
    if (!raw[17] && raw[16:15] != 2'b00) begin
      saturate = CODE_POS_FULL;
    end else if (raw[17] && raw[16:15] != 2'b11) begin
      saturate = CODE_NEG_FULL;
    end else begin
      saturate = raw[15:0];
    end
  endfunction

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    sel_s1_r <= SHIFT_CLOCK_SOURCE_SELECT;
    sel_s2_r <= sel_s1_r;
    tag_s1_r <= DAISY_CHAIN_INPUT;
    tag_s2_r <= tag_s1_r;
    ref_s1_r <= REFERENCE_SHUTDOWN;
    ref_s2_r <= ref_s1_r;
    // Serial bit from the shift clock domain; it only moves on falling
    // edges, so two flops settle it before the output register
    ext_s1_r <= ext_out;
    ext_s2_r <= ext_s1_r;
  end

  // ------------------------------------------------------------------
  // Reference control
  // ------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      REF_POWER_EN <= 1'b1;
    end else begin
      REF_POWER_EN <= !ref_s2_r;
    end
  end

  // ------------------------------------------------------------------
  // Result register and busy
  // ------------------------------------------------------------------
  // One-cycle clear of the external read position with each new result;
  // a pulse, so the host may start clocking one cycle after busy rises
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      result_r   <= RESULT_RESET;
      busy_n_r   <= 1'b1;
      load_clr_r <= 1'b1;
    end else if (CONV_START) begin
      busy_n_r   <= 1'b0;
      load_clr_r <= 1'b0;
    end else if (CONV_DONE && !busy_n_r) begin
      result_r   <= saturate(CONV_RAW);
      load_clr_r <= 1'b1;
      busy_n_r   <= 1'b1;
    end else begin
      load_clr_r <= 1'b0;
    end
  end
  assign BUSY_N = busy_n_r;

  // Previous data held valid for 12 us after a start; result_r is not
  // touched before CONV_DONE, so the old word stands at least that long
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      prev_cnt_r   <= '0;
      prev_valid_r <= 1'b1;
    end else if (CONV_START) begin
      prev_cnt_r   <= CNT_W'(PREV_VALID_CYC);
      prev_valid_r <= 1'b1;
    end else if (prev_cnt_r != '0) begin
      prev_cnt_r <= prev_cnt_r - 1'b1;
      if (prev_cnt_r == CNT_W'(1)) begin
        prev_valid_r <= busy_n_r;
      end
    end else if (busy_n_r) begin
      prev_valid_r <= 1'b1;
    end
  end
  assign PREV_DATA_VALID = prev_valid_r;

  // ------------------------------------------------------------------
  // Internal shift clock generator
  // ------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ick_r       <= IDLE;
      ick_cnt_r   <= '0;
      pulse_r     <= '0;
      sclk_r      <= 1'b0;
      int_sh_r    <= RESULT_RESET;
      int_tag_r   <= 1'b0;
      tag_taken_r <= 1'b0;
      int_out_r   <= 1'b0;
    end else begin
      case (ick_r)
        IDLE: begin
          sclk_r <= 1'b0;
          if (CONV_START && !sel_s2_r) begin
            int_sh_r    <= result_r;
            int_out_r   <= result_r[15];
            tag_taken_r <= 1'b0;
            ick_cnt_r   <= CNT_W'(START_DELAY_CYC);
            pulse_r     <= '0;
            ick_r       <= WAIT;
          end
        end
        WAIT: begin
          if (ick_cnt_r == '0) begin
            ick_cnt_r <= CNT_W'(SCLK_HALF_CYC);
            sclk_r    <= 1'b1;
            ick_r     <= PULSE;
            if (!tag_taken_r) begin
              int_tag_r   <= tag_s2_r;
              tag_taken_r <= 1'b1;
            end
          end else begin
            ick_cnt_r <= ick_cnt_r - 1'b1;
          end
        end
        PULSE: begin
          if (ick_cnt_r == '0) begin
            sclk_r  <= 1'b0;
            pulse_r <= pulse_r + 5'h01;
            int_sh_r <= {int_sh_r[14:0], int_tag_r};
            if (pulse_r + 5'h01 == PULSE_COUNT) begin
              int_out_r <= int_tag_r;
              ick_r     <= IDLE;
            end else begin
              int_out_r <= int_sh_r[14];
              ick_cnt_r <= CNT_W'(SCLK_HALF_CYC);
              ick_r     <= WAIT;
            end
          end else begin
            ick_cnt_r <= ick_cnt_r - 1'b1;
          end
        end
        default: ick_r <= IDLE;
      endcase
    end
  end
  assign SHIFT_CLOCK_PIN = sclk_r;

  // ------------------------------------------------------------------
  // External shift clock path
  // ------------------------------------------------------------------
  asrtc_ext_shifter u_ext (
    .sclk      (EXT_SHIFT_CLK),
    .load_clr  (load_clr_r),
    .load_word (result_r),
    .tag_in    (DAISY_CHAIN_INPUT),
    .ser_out   (ext_out)
  );

  // ------------------------------------------------------------------
  // Output select
  // ------------------------------------------------------------------
  // Output mux; the external bit arrives through its synchroniser
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      out_r <= 1'b0;
    end else begin
      out_r <= sel_s2_r ? ext_s2_r : int_out_r;
    end
  end
  assign SERIAL_RESULT_OUT = out_r;
endmodule // asrtc_serial_out
`default_nettype wire

// ===== core/asrtc_pkg.sv
// Package: constants for the serial result and tag chain logic.
// Assumes SYS_CLK at 250 MHz; external shift clock is a separate domain.
package asrtc_pkg;
  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int          RESULT_BITS      = 16;
  localparam logic [15:0] RESULT_RESET     = 16'h0000;
  localparam logic [15:0] CODE_POS_FULL    = 16'h7FFF;
  localparam logic [15:0] CODE_NEG_FULL    = 16'h8000;
  localparam int          RAW_BITS         = 18;
  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int          CLK_PERIOD_PS    = 4000;
  localparam int          PREV_VALID_NS    = 12000;
  localparam int          PREV_VALID_CYC   = PREV_VALID_NS * 1000 / CLK_PERIOD_PS;
  localparam int          SCLK_PERIOD_NS   = 1100;
  localparam int          SCLK_HALF_CYC    = SCLK_PERIOD_NS * 1000 / CLK_PERIOD_PS / 2;
  localparam int          START_DELAY_NS   = 1400;
  localparam int          START_DELAY_CYC  = START_DELAY_NS * 1000 / CLK_PERIOD_PS;
  localparam int          CNT_W            = 16;
  localparam logic [4:0]  PULSE_COUNT      = 5'h10;
  typedef enum logic [1:0] {IDLE, WAIT, PULSE} asrtc_ick_t;
endpackage

// ===== core/asrtc_ext_shifter.sv
// Serial output register clocked by the external shift clock.
// Assumes load_clr pulses from the SYS_CLK domain while the host holds
// the shift clock low, and load_word stays put until the next pulse.
`timescale 1ns/1ns
`default_nettype none
module asrtc_ext_shifter (
  input  wire logic        sclk,
  input  wire logic        load_clr,
  input  wire logic [15:0] load_word,
  input  wire logic        tag_in,
  output logic             ser_out
);
  import asrtc_pkg::*;
  logic [4:0]  bit_cnt_r;
  logic [4:0]  bit_idx;
  logic [16:0] chain_r;
  // ------------------------------------------------------------------
  // Position
  // ------------------------------------------------------------------
  // Cleared without a clock edge so the MSB is ready for the very first
  // falling edge; the host keeps the clock low around the release.
  always_ff @(posedge sclk or posedge load_clr) begin
    if (load_clr) begin
      bit_cnt_r <= 5'h00;
    end else if (bit_cnt_r != PULSE_COUNT + 5'h01) begin
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end
  assign bit_idx = PULSE_COUNT - bit_cnt_r;
  // ------------------------------------------------------------------
  // Shift
  // ------------------------------------------------------------------
  // Tag bits enter on every rising edge; 17 deep so the first one is
  // due just as the LSB has gone
  always_ff @(posedge sclk) begin
    chain_r <= {chain_r[15:0], tag_in};
  end
  // MSB valid on first falling edge, LSB on 16th, tag from 17th on
  always_ff @(negedge sclk) begin
    if (bit_cnt_r > PULSE_COUNT) begin
      ser_out <= chain_r[16];
    end else begin
      ser_out <= load_word[bit_idx[3:0]];
    end
  end
endmodule // asrtc_ext_shifter
`default_nettype wire

// ===== dv/asrtc_checker.sv
// Checker: port timing of the serial result block.
// Assumes it is bound to asrtc_serial_out.
`timescale 1ns/1ns
`default_nettype none
module asrtc_checker (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic CONV_START,
  input wire logic CONV_DONE,
  input wire logic REFERENCE_SHUTDOWN,
  input wire logic SHIFT_CLOCK_PIN,
  input wire logic BUSY_N,
  input wire logic REF_POWER_EN,
  input wire logic PREV_DATA_VALID
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  busy_fall_a: assert property (CONV_START |=> !BUSY_N)
    else $error("busy not low after start");
  busy_rise_a: assert property (!BUSY_N && CONV_DONE && !CONV_START |=> BUSY_N)
    else $error("busy not high after done");
  busy_hold_a: assert property (BUSY_N && !CONV_START |=> BUSY_N)
    else $error("busy fell without start");
  ref_off_a: assert property ($past(REFERENCE_SHUTDOWN, 3) |-> !REF_POWER_EN)
    else $error("reference not powered down");
  ref_on_a: assert property (!$past(REFERENCE_SHUTDOWN, 3) |-> REF_POWER_EN)
    else $error("reference not powered up");
  prev_hold_a: assert property (CONV_START |=> PREV_DATA_VALID [*8])
    else $error("previous result dropped early");
  prev_drop_a: assert property ($fell(PREV_DATA_VALID) |-> !BUSY_N)
    else $error("previous result dropped while idle");
  pulse_high_a: assert property ($rose(SHIFT_CLOCK_PIN) |=> SHIFT_CLOCK_PIN [*8])
    else $error("shift clock pulse too short");
  cover property (CONV_DONE && !BUSY_N);
  cover property ($rose(SHIFT_CLOCK_PIN));
  cover property ($fell(PREV_DATA_VALID));
endmodule // asrtc_checker
bind asrtc_serial_out asrtc_checker i_chk (.SYS_CLK, .RST_N, .CONV_START,
  .CONV_DONE, .REFERENCE_SHUTDOWN, .SHIFT_CLOCK_PIN, .BUSY_N,
  .REF_POWER_EN, .PREV_DATA_VALID);
`default_nettype wire

// ===== dv/asrtc_host_model.sv
// Host model: drives shift clock and tag, captures serial bits.
// Assumes the bench calls its tasks; the clock idles low otherwise.
`timescale 1ns/1ns
`default_nettype none
module asrtc_host_model (
  input  wire logic sdo,
  input  wire logic busy_n,
  input  wire logic int_clk,
  output logic      sclk,
  output logic      tag
);
  logic [39:0] got = '0;
  event done;
  initial begin
    sclk = 1'b0;
    tag = 1'b0;
  end
  // Clocks 1 ns after busy is high; the bench calls it after the load pulse has ended, so no edge lands in it
  // Samples after each falling edge; tag moves in the same step as each rising edge, just before it
  task automatic xread(input logic [23:0] tv);
    wait (busy_n === 1'b1);
    #1;
    tag = tv[23];
    for (int i = 0; i < 40; i++) begin
      sclk = 1'b1;
      #32 sclk = 1'b0;
      #32 got = {got[38:0], sdo};
      tag = (i < 23) ? tv[22 - i] : 1'b0;
    end
    ->done;
  endtask
  // Tag flips after the first rise to expose a late sample
  task automatic icap(input logic t);
    tag = t;
    got = '0;
    for (int i = 0; i < 16; i++) begin
      @(posedge int_clk);
      #22 got = {got[38:0], sdo};
      tag = ~t;
    end
    @(negedge int_clk);
    #600 got = {got[38:0], sdo};
    ->done;
  endtask
endmodule // asrtc_host_model
`default_nettype wire

// ===== dv/adc_serial_result_tag_chain_tb.sv
// Testbench: conversions, saturation, external and internal readout.
// Assumes the checker and host model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module adc_serial_result_tag_chain_tb;
  import asrtc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, sel = 1'b1, start = 1'b0;
  logic done_i = 1'b0, shut = 1'b0;
  logic sdo, sck, busy_n, ref_en, pdv, xclk, tag;
  logic [17:0] raw = '0;
  logic [15:0] prev = RESULT_RESET;
  logic [17:0] raws [5] = '{18'h00000, 18'h1FFFF, 18'h20000, 18'h08000,
                            18'h37FFF};
  logic [39:0] exp_q[$];
  int error_cnt = 0;
  int check_count = 0;
  always #2 clk = ~clk;
  asrtc_serial_out i_dut (
    .SYS_CLK(clk), .RST_N(rst_n), .EXT_SHIFT_CLK(xclk),
    .SHIFT_CLOCK_SOURCE_SELECT(sel), .DAISY_CHAIN_INPUT(tag),
    .CONV_START(start), .CONV_DONE(done_i), .CONV_RAW(raw),
    .REFERENCE_SHUTDOWN(shut), .SERIAL_RESULT_OUT(sdo),
    .SHIFT_CLOCK_PIN(sck), .BUSY_N(busy_n), .REF_POWER_EN(ref_en),
    .PREV_DATA_VALID(pdv));
  asrtc_host_model i_host (.sdo(sdo), .busy_n(busy_n), .int_clk(sck),
    .sclk(xclk), .tag(tag));
  task automatic check(input logic [39:0] seen, input logic [39:0] expd);
    check_count++;
    if (seen !== expd) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expd);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [15:0] sat(input logic signed [17:0] r);
    if (r > 18'sh07FFF) return CODE_POS_FULL;
    if (r < 18'sh38000) return CODE_NEG_FULL;
    return r[15:0];
  endfunction
  task automatic conv(input logic [17:0] r, input int wt);
    @(negedge clk) start = 1'b1;
    @(negedge clk) start = 1'b0;
    check(pdv, 1'b1);
    @(negedge clk) check(busy_n, 1'b0);
    repeat (wt) @(negedge clk);
    check(pdv, 1'b0);
    raw = r;
    done_i = 1'b1;
    @(negedge clk) done_i = 1'b0;
    @(negedge clk) check(busy_n, 1'b1);
    prev = sat(r);
  endtask
  // Every captured bit is compared at its fixed place in the stream
  always @(i_host.done) begin : mon
    logic [39:0] e;
    e = exp_q.pop_front();
    check(i_host.got, e);
  end
  initial begin : main
    logic t;
    logic [23:0] tv;
    void'($urandom(95));
    raws[0] = 18'($urandom_range(0, 65535)) - 18'h08000;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    shut = 1'b1;
    repeat (3) @(negedge clk);
    check(ref_en, 1'b0);
    shut = 1'b0;
    repeat (3) @(negedge clk);
    check(ref_en, 1'b1);
    $display("test ref done");
    foreach (raws[i]) begin
      tv = 24'($urandom);
      conv(raws[i], 3100);
      exp_q.push_back({sat(raws[i]), tv});
      i_host.xread(tv);
      $display("test ext %0d done", i);
    end
    @(negedge clk) sel = 1'b0;
    repeat (4) @(negedge clk);
    t = $urandom_range(0, 1);
    exp_q.push_back({23'h000000, prev, t});
    fork
      conv(18'h01234, 5000);
      i_host.icap(t);
    join
    $display("test int done");
    repeat (4) @(negedge clk);
    report_and_stop();
  end
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
endmodule // adc_serial_result_tag_chain_tb
`default_nettype wire
